// ==== core/tecc_pkg.sv ====
// Constants, field layouts and small decoders of the 16-bit timer/event counter.
// Assumes one clock domain; every file of the block imports this package.
package tecc_pkg;

	// Register indices on the plain register port
	localparam int          ADDR_W     = 3;
	localparam logic [2:0]  ADR_MODE   = 3'h0;
	localparam logic [2:0]  ADR_CCC    = 3'h1;
	localparam logic [2:0]  ADR_PSEL   = 3'h2;
	localparam logic [2:0]  ADR_CCA    = 3'h3;
	localparam logic [2:0]  ADR_CAPB   = 3'h4;
	localparam logic [2:0]  ADR_CNT    = 3'h5;
	localparam logic [2:0]  ADR_STAT   = 3'h6;

	// Operating modes held in mode_control_reg
	localparam int          MODE_W       = 3;
	localparam logic [2:0]  MODE_STOP    = 3'h0;
	localparam logic [2:0]  MODE_INTERVAL = 3'h1;
	localparam logic [2:0]  MODE_EVENT   = 3'h2;
	localparam logic [2:0]  MODE_FREE    = 3'h3;
	localparam logic [2:0]  MODE_RESTART = 3'h4;

	// Edge selection codes
	localparam logic [1:0]  ES_FALL    = 2'h0;
	localparam logic [1:0]  ES_RISE    = 2'h1;
	localparam logic [1:0]  ES_BAD     = 2'h2;
	localparam logic [1:0]  ES_BOTH    = 2'h3;

	// Count clock selection codes
	localparam logic [1:0]  CS_FULL    = 2'h0;
	localparam logic [1:0]  CS_DIV4    = 2'h1;
	localparam logic [1:0]  CS_DIV256  = 2'h2;
	localparam logic [1:0]  CS_EDGE    = 2'h3;

	// Prescaler
	localparam int          PRE_W      = 8;
	localparam logic [7:0]  PRE_DIV4   = 8'h03;
	localparam logic [7:0]  PRE_DIV256 = 8'hFF;

	// Field positions
	localparam int          CCC_W          = 2;
	localparam int          CCC_CAP_A_BIT  = 0;
	localparam int          CCC_SRC_INV_BIT = 1;
	localparam int          STAT_OVF_BIT   = 0;
	localparam int          PSEL_W         = 8;

	// Reset values
	localparam logic [7:0]  PSEL_RESET = 8'h00;
	localparam logic [1:0]  CCC_RESET  = 2'h0;

	typedef struct packed {
		logic [1:0] b_sel;
		logic [1:0] a_sel;
		logic [1:0] rsv;
		logic [1:0] clk_sel;
	} tecc_psel_t;

	typedef struct packed {
		logic rise;
		logic fall;
	} tecc_edge_t;

	// Edge accepted by a two-bit selection; the prohibited code accepts none
	function automatic logic tecc_edge_valid(input logic [1:0] sel, input tecc_edge_t e);
		logic r;
		r = 1'b0;
		case (sel)
			ES_FALL: r = e.fall;
			ES_RISE: r = e.rise;
			ES_BOTH: r = e.rise | e.fall;
			default: r = 1'b0;
		endcase
		return r;
	endfunction : tecc_edge_valid

	// Edge opposite to the selection; none when both edges are selected
	function automatic logic tecc_edge_inverse(input logic [1:0] sel, input tecc_edge_t e);
		logic r;
		r = 1'b0;
		case (sel)
			ES_FALL: r = e.rise;
			ES_RISE: r = e.fall;
			default: r = 1'b0;
		endcase
		return r;
	endfunction : tecc_edge_inverse

endpackage : tecc_pkg

// ==== core/tecc_edge_filt.sv ====
// Pin synchroniser and twice-sampled level filter with edge pulses.
// Assumes pin_i is asynchronous; sample_i is a one-cycle enable on clk_i.
module tecc_edge_filt
	import tecc_pkg::*;
(
	input  wire logic  clk_i,    // System clock
	input  wire logic  rst_i,    // Synchronous reset, high
	input  wire logic  pin_i,    // Asynchronous pin
	input  wire logic  sample_i, // Sampling enable
	output tecc_edge_t edge_o    // Filtered edge pulses
);

	logic sync1_r;
	logic sync2_r;
	logic seen_r;
	logic lvl_r;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
		end else begin
			sync1_r <= pin_i;
			sync2_r <= sync1_r;
		end
	end

	// New level must be seen on two successive samples
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			seen_r <= 1'b0;
			lvl_r  <= 1'b0;
			edge_o <= '0;
		end else begin
			edge_o <= '0;
			if (sample_i) begin
				seen_r <= sync2_r;
				if (sync2_r == seen_r && sync2_r != lvl_r) begin
					lvl_r       <= sync2_r;
					edge_o.rise <= sync2_r;
					edge_o.fall <= ~sync2_r;
				end
			end
		end
	end

endmodule : tecc_edge_filt

// ==== core/tecc_timer.sv ====
// Top of the 16-bit timer/event counter: registers, prescaler, counter, captures.
// Assumes one clock; pins are asynchronous and filtered before use.
//
// Decided for this implementation: the plain strobed port and the register addresses.

// Summary of operation
// - interval mode: match clears counter, raises match_irq_a
// - count clock from clock_select_bits, bits 0-1
// - 00 full, 01 div4, 10 div256, 11 edge
// - edge code 00 fall, 01 rise, 11 both
// - interval is compare value plus one ticks
// - clear modes: overflow only with compare FFFFH
// - lowered compare: count on, wrap, restart zero
// - event mode counts valid edges of edge_input_a
// - event mode: match clears counter, raises match_irq_a
// - input_a_edge_select sits at bits 4-5
// - event edges sampled at clock, seen twice
// - captures sampled at count clock (full rate with edge clock), seen twice
// - single capture: edge_input_a edge loads capture_b
// - dual: edge_input_a edge loads capture_b, irq
// - dual, CCC bit 1 clear: edge_input_b edge loads compare_capture_a, irq
// - free-running or restart-on-edge measurement
module tecc_timer
	import tecc_pkg::*;
#(
	parameter int CNT_W = 16 // Counter and data width
) (
	input  wire logic              clk_i,           // System clock, 50 MHz
	input  wire logic              rst_i,           // Synchronous reset, high
	input  wire logic [ADDR_W-1:0] addr_i,          // Register index
	input  wire logic [CNT_W-1:0]  wdata_i,         // Write data
	input  wire logic              we_i,            // Write strobe
	input  wire logic              re_i,            // Read strobe
	output logic      [CNT_W-1:0]  rdata_o,         // Read data, cycle after strobe
	input  wire logic              edge_input_a_i,  // Event / capture pin A
	input  wire logic              edge_input_b_i,  // Capture pin B
	output logic                   match_irq_a_o,   // Match or capture A from pin B pulse
	output logic                   capture_irq_b_o, // Capture B pulse
	output logic                   overflow_flag_o  // Sticky overflow
);

	generate
		if (CNT_W < PSEL_W) begin : g_chk
			$error("tecc_timer: CNT_W must be at least 8");
		end
	endgenerate

	localparam logic [CNT_W-1:0] CNT_MAX  = '1;
	localparam logic [CNT_W-1:0] CNT_ZERO = '0;

	function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] r);
		return a == r;
	endfunction : reg_hit

	logic [MODE_W-1:0] mode_r;
	logic [CCC_W-1:0]  ccc_r;
	tecc_psel_t        psel_r;
	logic [CNT_W-1:0]  cca_r;
	logic [CNT_W-1:0]  capb_r;
	logic [CNT_W-1:0]  cnt_r;
	logic [CNT_W-1:0]  cnt_nxt;
	logic [PRE_W-1:0]  pre_r;
	logic              ovf_r;

	logic              running;
	logic              clear_mode;
	logic              capture_mode;
	logic              pre_tick;
	logic              cap_smp;
	logic              cnt_tick;
	logic              at_cmp;
	logic              match_clr;
	logic              match_free;
	logic              a_fast_valid;
	logic              cap_a_edge;
	logic              restart_clr;
	logic              cap_b_pin;
	logic              cap_a_inv;
	logic              ovf_set;
	logic              ovf_clr;
	tecc_edge_t        ea_fast;
	tecc_edge_t        ea_cap;
	tecc_edge_t        eb_cap;

	assign running      = mode_r != MODE_STOP;
	assign clear_mode   = mode_r == MODE_INTERVAL || mode_r == MODE_EVENT;
	assign capture_mode = mode_r == MODE_FREE || mode_r == MODE_RESTART;

	// Mode register; illegal codes fall back to stop
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode_r <= MODE_STOP;
		end else if (we_i && reg_hit(addr_i, ADR_MODE)) begin
			if (wdata_i[MODE_W-1:0] > MODE_RESTART) begin
				mode_r <= MODE_STOP;
			end else begin
				mode_r <= wdata_i[MODE_W-1:0];
			end
		end
	end

	// Capture/compare control
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ccc_r <= CCC_RESET;
		end else if (we_i && reg_hit(addr_i, ADR_CCC)) begin
			ccc_r <= wdata_i[CCC_W-1:0];
		end
	end

	// Prescaler select; bits 2 and 3 always zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			psel_r <= PSEL_RESET;
		end else if (we_i && reg_hit(addr_i, ADR_PSEL)) begin
			psel_r     <= wdata_i[PSEL_W-1:0];
			psel_r.rsv <= '0;
		end
	end

	// Prescaler runs only while the timer runs
	always_ff @(posedge clk_i) begin
		if (rst_i || !running) begin
			pre_r <= '0;
		end else begin
			pre_r <= PRE_W'(pre_r + 1'b1);
		end
	end

	always_comb begin
		pre_tick = 1'b0;
		case (psel_r.clk_sel)
			CS_FULL:   pre_tick = 1'b1;
			CS_DIV4:   pre_tick = (pre_r & PRE_DIV4) == PRE_DIV4;
			CS_DIV256: pre_tick = pre_r == PRE_DIV256;
			default:   pre_tick = 1'b0;
		endcase
	end

	// Capture sampling follows the count clock; full rate when counting edges
	assign cap_smp = (psel_r.clk_sel == CS_EDGE) ? 1'b1 : pre_tick;

	tecc_edge_filt u_filt_a_fast (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.pin_i    (edge_input_a_i),
		.sample_i (1'b1),
		.edge_o   (ea_fast)
	);

	tecc_edge_filt u_filt_a_cap (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.pin_i    (edge_input_a_i),
		.sample_i (cap_smp),
		.edge_o   (ea_cap)
	);

	tecc_edge_filt u_filt_b_cap (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.pin_i    (edge_input_b_i),
		.sample_i (cap_smp),
		.edge_o   (eb_cap)
	);

	assign a_fast_valid = tecc_edge_valid(psel_r.a_sel, ea_fast);

	// Count tick: pin edges in event mode or with edge clock, else prescaler
	always_comb begin
		cnt_tick = 1'b0;
		if (running) begin
			if (mode_r == MODE_EVENT || psel_r.clk_sel == CS_EDGE) begin
				cnt_tick = a_fast_valid;
			end else begin
				cnt_tick = pre_tick;
			end
		end
	end

	assign at_cmp     = cnt_r == cca_r;
	assign match_clr  = clear_mode && cnt_tick && at_cmp;
	assign match_free = capture_mode && cnt_tick && at_cmp && !ccc_r[CCC_CAP_A_BIT];

	// Capture events
	assign cap_a_edge  = capture_mode && tecc_edge_valid(psel_r.a_sel, ea_cap);
	assign restart_clr = mode_r == MODE_RESTART && cap_a_edge;
	assign cap_b_pin   = capture_mode && ccc_r[CCC_CAP_A_BIT] && !ccc_r[CCC_SRC_INV_BIT]
		&& tecc_edge_valid(psel_r.b_sel, eb_cap);
	assign cap_a_inv   = capture_mode && ccc_r[CCC_CAP_A_BIT] && ccc_r[CCC_SRC_INV_BIT]
		&& tecc_edge_inverse(psel_r.a_sel, ea_cap);

	// Next counter value
	always_comb begin
		cnt_nxt = cnt_r;
		if (!running) begin
			cnt_nxt = CNT_ZERO;
		end else if (restart_clr) begin
			cnt_nxt = CNT_ZERO;
		end else if (match_clr) begin
			cnt_nxt = CNT_ZERO;
		end else if (cnt_tick) begin
			cnt_nxt = CNT_W'(cnt_r + 1'b1);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_r <= CNT_ZERO;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	// Overflow: wrap in free modes; in clear modes only with compare at max
	always_comb begin
		ovf_set = 1'b0;
		if (cnt_tick && cnt_r == CNT_MAX && !restart_clr) begin
			if (clear_mode) begin
				ovf_set = cca_r == CNT_MAX;
			end else begin
				ovf_set = 1'b1;
			end
		end
	end

	assign ovf_clr = we_i && reg_hit(addr_i, ADR_STAT) && wdata_i[STAT_OVF_BIT];

	// Set beats a same-cycle clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ovf_r <= 1'b0;
		end else if (ovf_set) begin
			ovf_r <= 1'b1;
		end else if (ovf_clr) begin
			ovf_r <= 1'b0;
		end
	end

	// Compare/capture A: hardware capture wins over a software write
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cca_r <= CNT_ZERO;
		end else if (cap_b_pin || cap_a_inv) begin
			cca_r <= cnt_r;
		end else if (we_i && reg_hit(addr_i, ADR_CCA)) begin
			cca_r <= wdata_i;
		end
	end

	// Capture B is loaded by hardware only
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			capb_r <= CNT_ZERO;
		end else if (cap_a_edge) begin
			capb_r <= cnt_r;
		end
	end

	// Interrupt request pulses
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			match_irq_a_o   <= 1'b0;
			capture_irq_b_o <= 1'b0;
		end else begin
			match_irq_a_o   <= match_clr || match_free || cap_b_pin;
			capture_irq_b_o <= cap_a_edge;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			overflow_flag_o <= 1'b0;
		end else begin
			overflow_flag_o <= ovf_set || (ovf_r && !ovf_clr);
		end
	end

	// Read port: data stand one cycle, zero otherwise
	always_ff @(posedge clk_i) begin
		if (rst_i || !re_i) begin
			rdata_o <= CNT_ZERO;
		end else begin
			rdata_o <= CNT_ZERO;
			case (addr_i)
				ADR_MODE: rdata_o[MODE_W-1:0] <= mode_r;
				ADR_CCC:  rdata_o[CCC_W-1:0]  <= ccc_r;
				ADR_PSEL: rdata_o[PSEL_W-1:0] <= psel_r;
				ADR_CCA:  rdata_o             <= cca_r;
				ADR_CAPB: rdata_o             <= capb_r;
				ADR_CNT:  rdata_o             <= cnt_r;
				ADR_STAT: rdata_o[STAT_OVF_BIT] <= ovf_r;
				default:  rdata_o             <= CNT_ZERO;
			endcase
		end
	end

endmodule : tecc_timer

// ==== verif/tecc_pin_model.sv ====
// Pin sources for the timer: two levels that flip on request, plus a glitch on A.
// Assumes requests are one-cycle pulses on clk_i.
module tecc_pin_model (
	input  wire logic clk_i,   // Bench clock
	input  wire logic rst_i,   // Reset, high
	input  wire logic tog_a_i, // Flip pin A
	input  wire logic tog_b_i, // Flip pin B
	input  wire logic gl_a_i,  // One-cycle glitch on A
	output logic      pin_a_o, // Pin A
	output logic      pin_b_o  // Pin B
);
	timeunit 1ns;
	timeprecision 1ns;
	logic lvl_a_r;
	logic lvl_b_r;
	logic gl_r;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lvl_a_r <= 1'b0;
			lvl_b_r <= 1'b0;
			gl_r    <= 1'b0;
		end else begin
			lvl_a_r <= lvl_a_r ^ tog_a_i;
			lvl_b_r <= lvl_b_r ^ tog_b_i;
			gl_r    <= gl_a_i;
		end
	end
	assign pin_a_o = lvl_a_r ^ gl_r;
	assign pin_b_o = lvl_b_r;
endmodule : tecc_pin_model

// ==== verif/tecc_timer_props.sv ====
// Concurrent checks on the timer top's ports.
// Assumes one clock; mode and compare are tracked from register writes.
module tecc_timer_props
	import tecc_pkg::*;
#(
	parameter int CNT_W = 16 // Counter width
) (
	input wire logic              clk_i,           // Clock
	input wire logic              rst_i,           // Reset
	input wire logic [ADDR_W-1:0] addr_i,          // Index
	input wire logic [CNT_W-1:0]  wdata_i,         // Write data
	input wire logic              we_i,            // Write strobe
	input wire logic              re_i,            // Read strobe
	input wire logic [CNT_W-1:0]  rdata_o,         // Read data
	input wire logic              edge_input_a_i,  // Pin A
	input wire logic              edge_input_b_i,  // Pin B
	input wire logic              match_irq_a_o,   // Irq A
	input wire logic              capture_irq_b_o, // Irq B
	input wire logic              overflow_flag_o  // Overflow
);
	logic [MODE_W-1:0] mode_r;
	logic [CNT_W-1:0]  cca_r;
	logic [3:0]        quiet_r;
	logic              clr_w;
	assign clr_w = we_i && addr_i == ADR_STAT && wdata_i[STAT_OVF_BIT];
	always_ff @(posedge clk_i) begin
		if (rst_i) mode_r <= MODE_STOP;
		else if (we_i && addr_i == ADR_MODE)
			mode_r <= (wdata_i[2:0] > MODE_RESTART) ? MODE_STOP : wdata_i[2:0];
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) cca_r <= '0;
		else if (we_i && addr_i == ADR_CCA) cca_r <= wdata_i;
	end
	// Cycles since the last configuration write
	always_ff @(posedge clk_i) begin
		if (rst_i || (we_i && addr_i <= ADR_CCA)) quiet_r <= 4'h0;
		else if (quiet_r != 4'hF) quiet_r <= quiet_r + 4'h1;
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	chk_rdata_idle: assert property (!re_i |=> rdata_o == '0)
		else $error("read data not zero outside read");
	chk_psel_rsv: assert property (re_i && addr_i == ADR_PSEL |=> rdata_o[3:2] == 2'h0)
		else $error("reserved selector bits read nonzero");
	chk_stop_count: assert property (mode_r == MODE_STOP && $past(mode_r) == MODE_STOP
		&& re_i && addr_i == ADR_CNT |=> rdata_o == '0)
		else $error("counter moved while stopped");
	chk_stop_silent: assert property (mode_r == MODE_STOP && $past(mode_r) == MODE_STOP
		|-> !match_irq_a_o && !capture_irq_b_o)
		else $error("interrupt while stopped");
	chk_irqa_pulse: assert property (match_irq_a_o |=> !match_irq_a_o)
		else $error("match pulse longer than one cycle");
	chk_irqb_pulse: assert property ($rose(capture_irq_b_o) |=> $fell(capture_irq_b_o))
		else $error("capture pulse longer than one cycle");
	chk_irqb_mode: assert property (mode_r != MODE_FREE && mode_r != MODE_RESTART
		&& $past(mode_r) == mode_r |-> !capture_irq_b_o)
		else $error("capture pulse outside measuring modes");
	chk_ovf_clear: assert property (overflow_flag_o && !clr_w && !$past(clr_w)
		|=> overflow_flag_o)
		else $error("overflow dropped without clear");
	chk_ovf_cmp: assert property (quiet_r >= 4'h4 && cca_r != '1
		&& (mode_r == MODE_INTERVAL || mode_r == MODE_EVENT) |-> !$rose(overflow_flag_o))
		else $error("overflow with compare below maximum");
endmodule : tecc_timer_props
bind tecc_timer tecc_timer_props #(.CNT_W(CNT_W)) i_tecc_timer_props (.clk_i, .rst_i, .addr_i,
	.wdata_i, .we_i, .re_i, .rdata_o, .edge_input_a_i, .edge_input_b_i, .match_irq_a_o,
	.capture_irq_b_o, .overflow_flag_o);

// ==== verif/testbench.sv ====
// Self-checking bench: register tasks, pin stimulus and expected values.
// Assumes the pin model beside the timer and the bound checker.
module testbench;
	import tecc_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int W = 8;
	logic         clk_i, rst_i, we_i, re_i, tga, tgb, gla, pin_a, pin_b, irq_a, irq_b, ovf;
	logic [2:0]   addr_i;
	logic [W-1:0] wdata_i, rdata_o, v1, v2;
	int           fails = 0;
	int           total_checks = 0;
	int           cyc = 0;
	int           na, nb, t1, t2;
	int           ec[4] = '{2, 2, 0, 0};
	int           ea[4] = '{0, 0, 0, 1};
	tecc_timer #(.CNT_W(W)) i_tecc_timer (.clk_i, .rst_i, .addr_i, .wdata_i, .we_i, .re_i,
		.rdata_o, .edge_input_a_i(pin_a), .edge_input_b_i(pin_b), .match_irq_a_o(irq_a),
		.capture_irq_b_o(irq_b), .overflow_flag_o(ovf));
	tecc_pin_model i_tecc_pin_model (.clk_i, .rst_i, .tog_a_i(tga), .tog_b_i(tgb),
		.gl_a_i(gla), .pin_a_o(pin_a), .pin_b_o(pin_b));
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cyc++;
		if (irq_a === 1'b1) na++;
		if (irq_b === 1'b1) nb++;
	end
	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : conclude
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic wr(input logic [2:0] a, input logic [W-1:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		we_i <= 1'b1;
		@(posedge clk_i);
		we_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [2:0] a, output logic [W-1:0] d);
		@(posedge clk_i);
		addr_i <= a;
		re_i <= 1'b1;
		@(posedge clk_i);
		re_i <= 1'b0;
		#1 d = rdata_o;
	endtask : rd
	task automatic rc(input logic [2:0] a, input logic [W-1:0] exp);
		logic [W-1:0] d;
		rd(a, d);
		check(16'(d), 16'(exp));
	endtask : rc
	task automatic setup(input logic [2:0] m, input logic [1:0] c, input logic [W-1:0] cmp,
			input logic [7:0] ps);
		wr(ADR_MODE, W'(MODE_STOP));
		wr(ADR_CCC, W'(c));
		wr(ADR_CCA, cmp);
		wr(ADR_PSEL, ps);
		wr(ADR_MODE, W'(m));
	endtask : setup
	task automatic zero();
		@(negedge clk_i);
		na = 0;
		nb = 0;
	endtask : zero
	task automatic pin(input int k, output int st);
		@(negedge clk_i);
		st = cyc;
		@(posedge clk_i);
		tga <= (k == 0);
		tgb <= (k == 1);
		gla <= (k == 2);
		@(posedge clk_i);
		tga <= 1'b0;
		tgb <= 1'b0;
		gla <= 1'b0;
		repeat (8) @(posedge clk_i);
	endtask : pin
	task automatic period(input int exp);
		int n;
		n = 0;
		for (int p = 0; p < 2; p++) begin
			n = 0;
			do begin
				@(negedge clk_i);
				n++;
			end while (irq_a !== 1'b1 && n < 2000);
		end
		if (n >= 2000) begin
			fails++;
			conclude();
		end
		check(16'(n), 16'(exp));
	endtask : period
	initial begin
		{rst_i, we_i, re_i, tga, tgb, gla, addr_i, wdata_i} = {1'b1, 5'h00, 3'h0, 8'h00};
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		rc(ADR_PSEL, 8'h00);
		wr(ADR_PSEL, 8'hFF);
		rc(ADR_PSEL, 8'hF3);
		wr(ADR_MODE, 8'h07);
		rc(ADR_MODE, 8'h00);
		rc(3'h7, 8'h00);
		for (int i = 0; i < 3; i++) begin
			setup(MODE_INTERVAL, 2'h0, 8'h02, 8'(i));
			period(3 * ((i == 2) ? 256 : (1 << (2 * i))));
		end
		for (int e = 0; e < 4; e++) begin
			setup(MODE_EVENT, 2'h0, 8'h03, 8'(e << 4));
			zero();
			pin(2, t1);
			repeat (4) pin(0, t1);
			rc(ADR_CNT, 8'(ec[e]));
			check(16'(na), 16'(ea[e]));
		end
		setup(MODE_INTERVAL, 2'h0, 8'h01, 8'h33);
		zero();
		repeat (2) pin(0, t1);
		check(16'(na), 16'h0001);
		setup(MODE_FREE, 2'h1, 8'h00, 8'h50);
		zero();
		pin(0, t1);
		repeat (13) @(posedge clk_i);
		pin(1, t2);
		rd(ADR_CAPB, v1);
		rd(ADR_CCA, v2);
		check(16'(W'(v2 - v1)), 16'(W'(t2 - t1)));
		check(16'(na), 16'h0001);
		check(16'(nb), 16'h0001);
		setup(MODE_RESTART, 2'h0, 8'hFF, 8'h10);
		pin(0, t1);
		zero();
		pin(0, t1);
		pin(0, t2);
		pin(0, t2);
		rc(ADR_CAPB, W'(t2 - t1 - 1));
		check(16'(nb), 16'h0002);
		setup(MODE_FREE, 2'h0, 8'h00, 8'h30);
		repeat (8) @(posedge clk_i);
		zero();
		pin(0, t1);
		rd(ADR_CAPB, v1);
		pin(0, t2);
		rd(ADR_CAPB, v2);
		check(16'(W'(v2 - v1)), 16'(W'(t2 - t1)));
		check(16'(nb), 16'h0002);
		setup(MODE_FREE, 2'h3, 8'h00, 8'h10);
		zero();
		pin(0, t1);
		pin(0, t2);
		rd(ADR_CAPB, v1);
		rd(ADR_CCA, v2);
		check(16'(W'(v1 - v2)), 16'(W'(t2 - t1)));
		check(16'(na), 16'h0000);
		wr(ADR_STAT, 8'h01);
		repeat (300) @(posedge clk_i);
		rc(ADR_STAT, 8'h01);
		wr(ADR_STAT, 8'h01);
		repeat (2) @(posedge clk_i);
		@(negedge clk_i);
		check(16'(ovf), 16'h0000);
		setup(MODE_INTERVAL, 2'h0, 8'hFF, 8'h00);
		wr(ADR_STAT, 8'h01);
		repeat (300) @(posedge clk_i);
		rc(ADR_STAT, 8'h01);
		setup(MODE_INTERVAL, 2'h0, 8'h64, 8'h00);
		repeat (80) @(posedge clk_i);
		wr(ADR_CCA, 8'h0A);
		wr(ADR_STAT, 8'h01);
		zero();
		repeat (120) @(posedge clk_i);
		check(16'(na), 16'h0000);
		repeat (200) @(posedge clk_i);
		check(16'(na > 0), 16'h0001);
		rc(ADR_STAT, 8'h00);
		setup(MODE_INTERVAL, 2'h0, 8'h0A, 8'h00);
		period(11);
		conclude();
	end
endmodule : testbench
